// ===== acs_pkg.sv
// Package for the channel scan sequencer: config fields, variants, states.
// Assumes a single 100 MHz clock domain and a plain strobe register port.
package acs_pkg;

    // Register offsets on the plain port
    localparam logic [1:0] ACS_OFF_CFG    = 2'h0;  // Config register
    localparam logic [1:0] ACS_OFF_STATUS = 2'h1;  // Scan status
    localparam logic [1:0] ACS_OFF_RESULT = 2'h2;  // Result pop
    localparam logic [1:0] ACS_OFF_START  = 2'h3;  // Write starts a scan

    // Config field positions
    localparam int ACS_F_SGL   = 0;
    localparam int ACS_F_CS_LO = 1;
    localparam int ACS_F_CS_HI = 4;
    localparam int ACS_F_SCAN_MODE_LO = 5;
    localparam int ACS_F_SCAN_MODE_HI = 6;
    localparam int ACS_F_REF_PIN_SELECT  = 7;
    localparam int ACS_F_EXTCK = 8;

    // Reset value: single-ended, input 0, scan 00, pin as analog input
    localparam logic [8:0] ACS_CFG_RST = 9'h001;

    // Variants
    localparam logic [1:0] ACS_VAR_4  = 2'h0;
    localparam logic [1:0] ACS_VAR_8  = 2'h1;
    localparam logic [1:0] ACS_VAR_12 = 2'h2;

    // Scan modes
    localparam logic [1:0] ACS_SCAN_UP     = 2'h0;
    localparam logic [1:0] ACS_SCAN_REPEAT = 2'h1;
    localparam logic [1:0] ACS_SCAN_UPPER  = 2'h2;
    localparam logic [1:0] ACS_SCAN_SINGLE = 2'h3;

    localparam logic [3:0] ACS_REPEAT_CNT = 4'h8;  // Repeat mode count
    localparam logic [3:0] ACS_START_HI   = 4'h6;  // Upper scan start, 8/12 in
    localparam logic [3:0] ACS_START_LO   = 4'h2;  // Upper scan start, 4 in
    localparam logic [3:0] ACS_CODE_RSV   = 4'hc;  // First reserved code
    localparam logic [3:0] ACS_TOP_PAIR4  = 4'h2;  // Top pair base, 4 in
    localparam logic [3:0] ACS_TOP_PAIR12 = 4'ha;  // Top pair base, 12 in
    localparam logic [3:0] ACS_GND        = 4'hf;  // Mux code meaning ground
    localparam int         ACS_DEPTH      = 16;    // Result memory entries
    localparam int         ACS_AW         = 4;

    // Mux selection handed to the analog front end
    typedef struct packed {
        logic [3:0] pos;   // Positive input, ACS_GND = ground
        logic [3:0] neg;   // Negative input, ACS_GND = ground
    } acs_mux_t;

    typedef enum logic [1:0] {
        ACS_IDLE,
        ACS_CONV,
        ACS_WAIT
    } acs_state_t;

endpackage

// ===== acs_scan_seq.sv
// Channel selection and scan sequencer of a multichannel 8-bit converter.
// Assumes a converter core that takes conv_req_o and answers with conv_done_i.
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/10ps
module acs_scan_seq
    import acs_pkg::*;
#(
    parameter logic [1:0] VARIANT = ACS_VAR_12  // Input count variant
) (
    input  wire logic       clock_i,      // 100 MHz clock
    input  wire logic       srst_i,       // Sync reset, active high
    input  wire logic       ce_i,         // Clock enable
    input  wire logic [1:0] addr_i,       // Register address
    input  wire logic [8:0] wdata_i,      // Write data
    input  wire logic       wr_i,         // Write strobe
    input  wire logic       rd_i,         // Read strobe
    output logic      [8:0] rdata_o,      // Read data, next cycle
    input  wire logic       host_nack_i,  // Host NACK pulse, stops ext scans in scan 01 or 11
    output logic            conv_req_o,   // Start one conversion
    output acs_mux_t        mux_o,        // Input selection
    input  wire logic       conv_done_i,  // Conversion finished pulse
    input  wire logic [7:0] conv_data_i,  // Result with conv_done_i
    output logic            ref_pin_o,    // Shared pin used as reference
    output logic            busy_o        // Scan in progress
);

    // Configuration and state registers
    logic [8:0]       cfg_q;
    acs_state_t       st_q, st_d;
    logic [3:0]       ch_q, ch_d;    // Current channel or pair index
    logic [3:0]       cnt_q, cnt_d;  // Conversions done in this scan
    logic [7:0]       mem_q [ACS_DEPTH];
    logic [ACS_AW-1:0] wp_q, rp_q;
    logic [ACS_AW:0]  fill_q;
    logic [8:0]       rdata_q;

    // Decoded configuration
    wire       sgl_w   = cfg_q[ACS_F_SGL];
    wire [1:0] scan_w  = {cfg_q[ACS_F_SCAN_MODE_HI], cfg_q[ACS_F_SCAN_MODE_LO]};
    wire       ref_pin_select_w  = cfg_q[ACS_F_REF_PIN_SELECT];
    wire       extck_w = cfg_q[ACS_F_EXTCK];
    wire [3:0] cs_raw  = cfg_q[ACS_F_CS_HI:ACS_F_CS_LO];
    // Variant masking of the select code
    wire [3:0] cs_w = (VARIANT == ACS_VAR_4) ? {2'h0, cs_raw[1:0]} :
                      (VARIANT == ACS_VAR_8) ? {1'h0, cs_raw[2:0]} :
                      cs_raw;
    wire       rsv_w    = (cs_w >= ACS_CODE_RSV);
    wire       has_sh_w = (VARIANT != ACS_VAR_8);
    wire [3:0] shared_w = (VARIANT == ACS_VAR_4) ? ACS_TOP_PAIR4 + 4'h1
                                                 : ACS_TOP_PAIR12 + 4'h1;
    assign ref_pin_o = ref_pin_select_w & has_sh_w;

    // First channel and last channel of a scan
    wire [3:0] up_start_w = (VARIANT == ACS_VAR_4) ? ACS_START_LO : ACS_START_HI;
    wire       multi_w    = ~scan_w[0];                               // Scan 00 or 10
    wire [3:0] first_w    = (scan_w == ACS_SCAN_UP)    ? 4'h0 :
                            (scan_w == ACS_SCAN_UPPER) ? up_start_w
                                                       : cs_w;
    wire [3:0] last_w = (scan_w == ACS_SCAN_UPPER && cs_w < up_start_w)
                        ? up_start_w : cs_w;
    // Differential scans step by pairs: bit 0 picks even or odd polarity
    wire [3:0] first_d_w = (sgl_w | ~multi_w) ? first_w
                                              : {first_w[3:1], cs_w[0]};
    wire [3:0] step_w    = (sgl_w | ~multi_w) ? 4'h1 : 4'h2;
    wire       at_last_w = (ch_q[3:1] >= last_w[3:1]) &
                           (sgl_w | ~multi_w ? ch_q >= last_w : 1'b1);

    // Mux code from the current channel
    wire [3:0] pair_p_w = ch_q;
    wire [3:0] pair_n_w = {ch_q[3:1], ~ch_q[0]};
    wire       top_pr_w = ref_pin_o & (ch_q[3:1] == shared_w[3:1]);
    acs_mux_t  mux_w;
    assign mux_w.pos = sgl_w ? ((ref_pin_o && ch_q == shared_w) ? ACS_GND : ch_q)
                             : ((top_pr_w && pair_p_w == shared_w) ? ACS_GND
                                                                   : pair_p_w);
    assign mux_w.neg = sgl_w ? ACS_GND
                             : ((top_pr_w && pair_n_w == shared_w) ? ACS_GND
                                                                   : pair_n_w);

    // Scan end decision after each conversion
    wire start_w = wr_i & (addr_i == ACS_OFF_START) & ~rsv_w;
    wire rep_w   = (scan_w == ACS_SCAN_REPEAT);
    wire done_w  = extck_w & ~multi_w ? host_nack_i :
                   rep_w ? (cnt_q + 4'h1 >= ACS_REPEAT_CNT) :
                   ~multi_w ? 1'b1 :
                   at_last_w;

    // Sequencer state machine
    always_comb begin
        st_d  = st_q;
        ch_d  = ch_q;
        cnt_d = cnt_q;
        case (st_q)
            ACS_IDLE: begin
                if (start_w) begin
                    st_d  = ACS_CONV;
                    ch_d  = first_d_w;
                    cnt_d = 4'h0;
                end
            end
            ACS_CONV: st_d = ACS_WAIT;
            ACS_WAIT: begin
                if (extck_w && !multi_w && host_nack_i) begin
                    st_d = ACS_IDLE;
                end else if (conv_done_i) begin
                    cnt_d = cnt_q + 4'h1;
                    if (done_w && !(extck_w && !multi_w)) begin
                        st_d = ACS_IDLE;
                    end else begin
                        st_d = ACS_CONV;
                        if (multi_w) begin
                            ch_d = ch_q + step_w;
                        end
                    end
                end
            end
            default: st_d = ACS_IDLE;
        endcase
    end

    assign conv_req_o = (st_q == ACS_CONV);
    assign busy_o     = (st_q != ACS_IDLE);
    wire pop_w = rd_i & (addr_i == ACS_OFF_RESULT) & (fill_q != '0);
    wire push_w = (st_q == ACS_WAIT) & conv_done_i;

    // Read data mux
    wire [8:0] rmux_w = (addr_i == ACS_OFF_CFG)    ? cfg_q :
                        (addr_i == ACS_OFF_STATUS) ? {3'h0, fill_q, busy_o} :
                        (addr_i == ACS_OFF_RESULT) ? {1'h0, mem_q[rp_q]} : 9'h000;

    // State and config registers
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            cfg_q <= ACS_CFG_RST;
            st_q  <= ACS_IDLE;
            ch_q  <= 4'h0;
            cnt_q <= 4'h0;
        end else if (ce_i) begin
            if (wr_i && addr_i == ACS_OFF_CFG && !busy_o) begin
                cfg_q <= wdata_i;
            end
            st_q  <= st_d;
            ch_q  <= ch_d;
            cnt_q <= cnt_d;
        end
    end

    // Result memory in conversion order; new scan restarts it
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            wp_q    <= '0;
            rp_q    <= '0;
            fill_q  <= '0;
            rdata_q <= 9'h000;
        end else if (ce_i) begin
            rdata_q <= rd_i ? rmux_w : 9'h000;
            if (start_w && st_q == ACS_IDLE) begin
                wp_q   <= '0;
                rp_q   <= '0;
                fill_q <= '0;
            end else begin
                if (push_w) begin
                    mem_q[wp_q] <= conv_data_i;
                    wp_q        <= wp_q + 1'b1;
                end
                if (pop_w) begin
                    rp_q <= rp_q + 1'b1;
                end
                if (push_w && !pop_w && fill_q != ACS_DEPTH[ACS_AW:0]) begin
                    fill_q <= fill_q + 1'b1;
                end else if (pop_w && !push_w) begin
                    fill_q <= fill_q - 1'b1;
                end
            end
        end
    end

    // Registered data outputs
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            mux_o <= '0;
        end else if (ce_i) begin
            mux_o <= mux_w;
        end
    end
    assign rdata_o = rdata_q;

    // Checks
    a_cs_mask: assert property (@(posedge clock_i) disable iff (srst_i)
        VARIANT != ACS_VAR_4 || cs_w[3:2] == 2'h0)
        else $error("select bits not masked");
    a_sgl_gnd: assert property (@(posedge clock_i) disable iff (srst_i)
        ce_i && sgl_w && ref_pin_o && ch_q == shared_w |=> mux_o.pos == ACS_GND)
        else $error("shared pin not ground");
    a_pair_pol: assert property (@(posedge clock_i) disable iff (srst_i)
        ce_i && !sgl_w && !top_pr_w |=> mux_o.pos == $past(ch_q)
                                     && mux_o.neg == {$past(ch_q[3:1]), ~$past(ch_q[0])})
        else $error("pair polarity wrong");
    a_diff_step: assert property (@(posedge clock_i) disable iff (srst_i)
        ce_i && st_q == ACS_WAIT && conv_done_i && !sgl_w && multi_w && st_d == ACS_CONV
        |=> ch_q == $past(ch_q) + 4'h2)
        else $error("pair step wrong");
    a_top_gnd: assert property (@(posedge clock_i) disable iff (srst_i)
        ce_i && !sgl_w && top_pr_w && pair_n_w == shared_w |=> mux_o.neg == ACS_GND)
        else $error("top pair not ground");
    a_scan_first: assert property (@(posedge clock_i) disable iff (srst_i)
        ce_i && start_w && st_q == ACS_IDLE && scan_w == ACS_SCAN_UP && sgl_w
        |=> ch_q == 4'h0)
        else $error("scan not from zero");
    a_rep_count: assert property (@(posedge clock_i) disable iff (srst_i)
        st_q != ACS_IDLE && rep_w && !extck_w |-> cnt_q < ACS_REPEAT_CNT)
        else $error("repeat count exceeded");
    a_upper_start: assert property (@(posedge clock_i) disable iff (srst_i)
        ce_i && start_w && st_q == ACS_IDLE && scan_w == ACS_SCAN_UPPER && sgl_w
        |=> ch_q == $past(up_start_w))
        else $error("upper scan start wrong");
    a_single_once: assert property (@(posedge clock_i) disable iff (srst_i)
        ce_i && st_q == ACS_WAIT && conv_done_i && scan_w == ACS_SCAN_SINGLE && !extck_w
        |=> st_q == ACS_IDLE)
        else $error("single conversion repeated");
    a_ext_nack: assert property (@(posedge clock_i) disable iff (srst_i)
        ce_i && st_q == ACS_WAIT && extck_w && !multi_w && host_nack_i
        |=> st_q == ACS_IDLE)
        else $error("nack did not stop");
    a_res_order: assert property (@(posedge clock_i) disable iff (srst_i)
        ce_i && push_w && !(start_w && st_q == ACS_IDLE) |=> wp_q == $past(wp_q) + 1'b1)
        else $error("write pointer stuck");

    // Helper count of requests since the scan began; it saturates so that a
    // runaway scan still trips the total checks instead of wrapping to zero
    logic [4:0] req_cnt_q;
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            req_cnt_q <= 5'h00;
        end else if (ce_i) begin
            if (start_w && st_q == ACS_IDLE) begin
                req_cnt_q <= 5'h00;
            end else if (conv_req_o && req_cnt_q != 5'h1f) begin
                req_cnt_q <= req_cnt_q + 5'h01;
            end
        end
    end

    // Steps of one conversion: start taken in idle, request, answer in wait
    sequence s_start_taken;
        ce_i && start_w && st_q == ACS_IDLE;
    endsequence
    sequence s_req_cycle;
        ce_i && conv_req_o;
    endsequence
    sequence s_done_in_wait;
        ce_i && st_q == ACS_WAIT && conv_done_i;
    endsequence

    // Start leads to one request cycle and then the wait for the core
    a_start_req: assert property (@(posedge clock_i) disable iff (srst_i)
        s_start_taken ##1 s_req_cycle |=> st_q == ACS_WAIT && !conv_req_o)
        else $error("request not one cycle");
    a_start_conv: assert property (@(posedge clock_i) disable iff (srst_i)
        s_start_taken |=> conv_req_o && busy_o)
        else $error("start gave no request");
    // External clock: a result without a refusal keeps the scan going
    a_ext_cont: assert property (@(posedge clock_i) disable iff (srst_i)
        s_done_in_wait ##0 (extck_w && !multi_w && !host_nack_i) |=> st_q == ACS_CONV)
        else $error("external scan stopped early");
    // Repeat mode: results before the last one start another request
    a_rep_cont: assert property (@(posedge clock_i) disable iff (srst_i)
        s_done_in_wait ##0 (rep_w && !extck_w && cnt_q + 4'h1 < ACS_REPEAT_CNT)
        |=> conv_req_o)
        else $error("repeat scan ended early");
    a_rep_end: assert property (@(posedge clock_i) disable iff (srst_i)
        s_done_in_wait ##0 (rep_w && !extck_w && cnt_q + 4'h1 == ACS_REPEAT_CNT)
        |=> !busy_o)
        else $error("repeat scan ran past count");

    // Request totals per scan kind
    a_rep_total: assert property (@(posedge clock_i) disable iff (srst_i)
        busy_o && rep_w && !extck_w |-> req_cnt_q <= 5'(ACS_REPEAT_CNT))
        else $error("too many repeat requests");
    a_single_total: assert property (@(posedge clock_i) disable iff (srst_i)
        busy_o && scan_w == ACS_SCAN_SINGLE && !extck_w |-> req_cnt_q <= 5'h01)
        else $error("too many single requests");
    a_up_total: assert property (@(posedge clock_i) disable iff (srst_i)
        busy_o && scan_w == ACS_SCAN_UP |-> req_cnt_q <= 5'(ACS_CODE_RSV))
        else $error("too many upward requests");

    // Single-ended selection and the top pair's positive side
    a_sgl_input: assert property (@(posedge clock_i) disable iff (srst_i)
        ce_i && sgl_w && !ref_pin_o |=> mux_o.pos == $past(ch_q)
                                     && mux_o.neg == ACS_GND)
        else $error("single-ended input wrong");
    a_top_pos: assert property (@(posedge clock_i) disable iff (srst_i)
        ce_i && !sgl_w && top_pr_w && pair_p_w == shared_w |=> mux_o.pos == ACS_GND)
        else $error("top pair positive not ground");
    // Channels stay inside the valid codes during a scan
    a_sgl_range: assert property (@(posedge clock_i) disable iff (srst_i)
        busy_o && sgl_w |-> ch_q < ACS_CODE_RSV)
        else $error("input index out of range");
    a_pair_range: assert property (@(posedge clock_i) disable iff (srst_i)
        busy_o && !sgl_w |-> ch_q < ACS_CODE_RSV)
        else $error("pair index out of range");
    a_upper_range: assert property (@(posedge clock_i) disable iff (srst_i)
        busy_o && scan_w == ACS_SCAN_UPPER && sgl_w |-> ch_q >= up_start_w)
        else $error("upper scan below start");

    // Refused requests leave the sequencer and configuration alone
    a_rsv_refused: assert property (@(posedge clock_i) disable iff (srst_i)
        ce_i && wr_i && addr_i == ACS_OFF_START && st_q == ACS_IDLE && rsv_w
        |=> st_q == ACS_IDLE)
        else $error("reserved code started");
    a_cfg_locked: assert property (@(posedge clock_i) disable iff (srst_i)
        ce_i && busy_o |=> cfg_q == $past(cfg_q))
        else $error("config changed in scan");
    a_reset_sgl: assert property (@(posedge clock_i) disable iff (srst_i)
        $fell(srst_i) |-> cfg_q == ACS_CFG_RST && sgl_w)
        else $error("config not reset");

    // Result memory pointers, bounds and idle read data
    a_pop_order: assert property (@(posedge clock_i) disable iff (srst_i)
        ce_i && pop_w && !(start_w && st_q == ACS_IDLE) |=> rp_q == $past(rp_q) + 1'b1)
        else $error("read pointer stuck");
    a_fill_bound: assert property (@(posedge clock_i) disable iff (srst_i)
        fill_q <= ACS_DEPTH)
        else $error("fill count overflow");
    a_rdata_idle: assert property (@(posedge clock_i) disable iff (srst_i)
        ce_i && !rd_i |=> rdata_o == 9'h000)
        else $error("read data not cleared");
    a_eight_mask: assert property (@(posedge clock_i) disable iff (srst_i)
        VARIANT != ACS_VAR_8 || cs_w[3] == 1'b0)
        else $error("top select bit not masked");

endmodule

// ===== acs_conv_model.sv
// Behavioural converter core that answers each request after 1 to 4 cycles.
// Assumes the sequencer holds mux_o steady while it waits for the answer.
`timescale 1ns/10ps
module acs_conv_model
    import acs_pkg::*;
(
    input  wire logic     clock_i,     // Bench clock
    input  wire logic     srst_i,      // Sync reset
    input  wire logic     conv_req_i,  // Conversion request
    input  wire acs_mux_t mux_i,       // Selected inputs
    output logic          done_o,      // Result ready pulse
    output logic [7:0]    data_o       // Result, echoes the selection
);
    logic [2:0] wait_q;
    logic [7:0] lfsr_q;
    // Result echoes the selection so the bench sees which pair was taken;
    // data toggles between answers so nothing stale passes for a result
    always_ff @(posedge clock_i) begin
        done_o <= 1'b0;
        data_o <= ~data_o;
        lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
        if (srst_i) begin
            wait_q <= 3'h0;
            lfsr_q <= 8'h5a;
            data_o <= 8'h00;
        end else if (wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
            if (wait_q == 3'h1) begin
                done_o <= 1'b1;
                data_o <= mux_i;
            end
        end else if (conv_req_i) begin
            wait_q <= {1'b0, lfsr_q[1:0]} + 3'h1;
        end
    end
endmodule

// ===== testbench.sv
// Self-checking bench for the scan sequencer, 12-input variant.
// Assumes acs_pkg and the converter core model are compiled first.
`timescale 1ns/10ps
module testbench;
    import acs_pkg::*;
    logic        clock_i     = 1'b0;
    logic        srst_i      = 1'b1;
    logic [1:0]  addr_i      = 2'h0;
    logic [8:0]  wdata_i     = 9'h000;
    logic        wr_i        = 1'b0;
    logic        rd_i        = 1'b0;
    logic        host_nack_i = 1'b0;
    logic [8:0]  rdata_o;
    logic        conv_req_o;
    logic        conv_done_i;
    logic        ref_pin_o;
    logic        busy_o;
    logic [7:0]  conv_data_i;
    acs_mux_t    mux_o;
    int          fails       = 0;
    int          cmp_count   = 0;
    logic [31:0] seed        = 32'h1f0558cc;
    logic [8:0]  rv;
    logic [8:0]  corner [6]  = '{9'h096, 9'h014, 9'h0f7, 9'h047, 9'h02b, 9'h0d6};

    always #5 clock_i = ~clock_i;

    acs_scan_seq dut (.clock_i(clock_i), .srst_i(srst_i), .ce_i(1'b1), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .host_nack_i(host_nack_i), .conv_req_o(conv_req_o), .mux_o(mux_o),
        .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .ref_pin_o(ref_pin_o),
        .busy_o(busy_o));
    acs_conv_model core (.clock_i(clock_i), .srst_i(srst_i), .conv_req_i(conv_req_o),
        .mux_i(mux_o), .done_o(conv_done_i), .data_o(conv_data_i));

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // First index of a scan; differential scans keep the select parity
    function automatic int first_idx(input logic [8:0] c);
        if (c[5]) return int'(c[4:1]);
        if (c[6]) return c[0] ? 6 : 6 + int'(c[1]);
        return c[0] ? 0 : int'(c[1]);
    endfunction
    function automatic int scan_len(input logic [8:0] c);
        int f;
        f = first_idx(c);
        if (c[6:5] == ACS_SCAN_REPEAT) return 8;
        if (c[6:5] == ACS_SCAN_SINGLE) return 1;
        if (f > int'(c[4:1])) return 1;
        return (int'(c[4:1]) - f) / (c[0] ? 1 : 2) + 1;
    endfunction
    // Shared pin reads as ground once it serves as reference
    function automatic logic [7:0] exp_mux(input logic [8:0] c, input int k);
        logic [3:0] p;
        logic [3:0] n;
        p = 4'(first_idx(c) + (c[5] ? 0 : k * (c[0] ? 1 : 2)));
        n = c[0] ? ACS_GND : p ^ 4'h1;
        if (c[7] && p == 4'hb) p = ACS_GND;
        if (c[7] && n == 4'hb) n = ACS_GND;
        return {p, n};
    endfunction

    task automatic check_val(input string what, input logic [8:0] exp, input logic [8:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [8:0] d);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, output logic [8:0] d);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask
    task automatic run_scan(input logic [8:0] c);
        logic [8:0] d;
        int i;
        wr(ACS_OFF_CFG, c);
        wr(ACS_OFF_START, 9'h000);
        @(posedge clock_i);
        #1;
        check_val("busy", 9'h001, {8'h00, busy_o});
        for (i = 0; i < 400 && busy_o !== 1'b0; i++) begin
            @(posedge clock_i);
            #1;
        end
        #1;
        check_val("ref pin", {8'h00, c[7]}, {8'h00, ref_pin_o});
        rd(ACS_OFF_STATUS, d);
        check_val("status", {3'h0, 5'(scan_len(c)), 1'b0}, d);
        for (i = 0; i < scan_len(c); i++) begin
            rd(ACS_OFF_RESULT, d);
            check_val("result", {1'b0, exp_mux(c, i)}, d);
        end
    endtask
    // External clock scans run past eight until the host refuses a byte
    task automatic run_ext(input logic [8:0] c);
        logic [8:0] d;
        int i;
        int n;
        wr(ACS_OFF_CFG, c);
        wr(ACS_OFF_START, 9'h000);
        d = 9'h000;
        for (i = 0; i < 200 && d[5:1] < 5'h9; i++) rd(ACS_OFF_STATUS, d);
        check_val("ext busy", 9'h001, {8'h00, busy_o});
        @(posedge clock_i);
        host_nack_i <= 1'b1;
        for (i = 0; i < 50 && busy_o !== 1'b0; i++) begin
            @(posedge clock_i);
            #1;
        end
        @(posedge clock_i);
        host_nack_i <= 1'b0;
        rd(ACS_OFF_STATUS, d);
        check_val("ext stop", 9'h000, {8'h00, d[0]});
        n = int'(d[5:1]);
        for (i = 0; i < n; i++) begin
            rd(ACS_OFF_RESULT, d);
            check_val("ext result", {1'b0, exp_mux(c, 0)}, d);
        end
    endtask
    task automatic give_verdict();
        if (fails == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Main sequence: reset value, corners, random configs, refusals, external mode
    initial begin
        repeat (3) @(posedge clock_i);
        srst_i <= 1'b0;
        rd(ACS_OFF_CFG, rv);
        check_val("cfg reset", 9'h001, rv);
        @(posedge clock_i);
        #1;
        check_val("rdata idle", 9'h000, rdata_o);
        foreach (corner[j]) run_scan(corner[j]);
        for (int j = 0; j < 40; j++) begin
            seed = xorshift(seed);
            rv = {1'b0, seed[7:5], 4'(seed[15:8] % 12), seed[0]};
            run_scan(rv);
        end
        for (int j = 12; j < 16; j++) begin
            wr(ACS_OFF_CFG, {4'h0, 4'(j), 1'b1});
            wr(ACS_OFF_START, 9'h000);
            @(posedge clock_i);
            #1;
            check_val("reserved", 9'h000, {8'h00, busy_o});
        end
        run_ext(9'h12b);
        run_ext(9'h168);
        give_verdict();
    end
    // Watchdog well beyond the few thousand cycles the tests need
    initial begin
        repeat (60000) @(posedge clock_i);
        fails++;
        give_verdict();
    end
endmodule
